// [rcd_pkg.sv]
// ============================================================
// shared constants and carriers of the reset cause block
package rcd_pkg;

    // ============================================================
    // register offsets on the cpu data address space
    localparam logic [15:0] RCD_DET_CTRL_ADDR = 16'hFF50;
    localparam logic [15:0] RCD_THR_SEL_ADDR = 16'hFF51;
    localparam logic [15:0] RCD_CAUSE_ADDR = 16'hFF54;

    // ============================================================
    // field positions
    localparam int RCD_CAUSE_WDT_BIT = 4;  // watchdog cause flag
    localparam int RCD_CAUSE_LV_BIT = 0;   // low-voltage cause flag
    localparam int RCD_CTRL_EN_BIT = 7;    // detector enable bit
    localparam int RCD_CTRL_MODE_BIT = 1;  // detector action select
    localparam int RCD_CTRL_FLAG_BIT = 0;  // low-voltage flag
    localparam int RCD_THR_W = 4;          // threshold code width

    // ============================================================
    // reset values
    localparam logic [7:0] RCD_CAUSE_RST = 8'h00;
    localparam logic [7:0] RCD_CTRL_RST = 8'h00;
    localparam logic [7:0] RCD_THR_RST = 8'h00;
    localparam logic [7:0] RCD_UNMAPPED_RD = 8'h00;

    // ============================================================
    // detector levels: codes 0 .. 9, the rest prohibited
    localparam int RCD_NUM_LEVELS = 10;

    // ============================================================
    // one cpu memory manipulation request
    typedef struct packed {
        logic rd;           // byte read
        logic wr;           // byte write
        logic bit_wr;       // single-bit write
        logic [15:0] addr;  // target address
        logic [7:0] wdata;  // byte write data
        logic [2:0] bit_idx;  // bit position of a bit write
        logic bit_val;      // value of a bit write
    } rcd_req_t;

    // events arriving from the rest of the chip
    typedef struct packed {
        logic wdt_req;      // watchdog timer reset request, pulse
        logic poc_below;    // supply under power-on-clear level
        logic cmp_below;    // analog comparator: supply under level
    } rcd_evt_t;

endpackage

// [rcd_reset_cause.sv]
`timescale 1ns/1ps

// What this block does
// - cause register clears on pin, power-clear, read
// - watchdog request sets cause bit 4
// - detector reset sets cause bit 0
// - watchdog/detector resets keep the other flag
// - cause register read-only, other bits zero
// - power-clear resets at power-up and while supply low
// - enable bit 7 starts comparator, 0 stops
// - control bit 1: 0 interrupt, 1 reset
// - flag is 1 only while enabled and low
// - flag bit ignores software writes
// - interrupt follows flag when enabled, interrupt mode
// - control register bit/byte writable, detector reset keeps
// - threshold register byte writable, detector reset keeps
// - four-bit code picks ten levels, rest prohibited
// - threshold write while enabled gives undefined level
// - reset mode holds reset while supply stays low
// - no reset when mode chosen above threshold
module rcd_reset_cause
    import rcd_pkg::*;
#(
    parameter int NUM_LEVELS = RCD_NUM_LEVELS  // legal threshold codes
) (
    input wire logic i_ref_clk,           // system clock, 250 MHz
    input wire logic i_resetn,            // external reset pin, low
    input wire rcd_req_t i_req,           // cpu register request
    input wire rcd_evt_t i_evt,           // watchdog, power, comparator
    output logic [7:0] o_rdata,           // read data, registered
    output logic o_cmp_enable,            // powers the comparator
    output logic [RCD_THR_W-1:0] o_level_code,  // selected level code
    output logic o_level_legal,           // code is not prohibited
    output logic o_low_voltage_flag,      // synchronised flag
    output logic o_low_voltage_irq,       // interrupt request level
    output logic o_lvi_reset,             // detector internal reset
    output logic o_poc_reset              // power-on-clear reset
);

    // ============================================================
    // elaboration check
    if (NUM_LEVELS < 1 || NUM_LEVELS > (1 << RCD_THR_W)) begin : g_bad_levels
        $error("NUM_LEVELS out of range for a 4-bit code");
    end

    // ============================================================
    // state of the block
    typedef struct packed {
        logic wdt_flag;     // watchdog cause flag
        logic lv_flag;      // low-voltage cause flag
        logic en;           // detector enable bit
        logic mode;         // detector action select
        logic [RCD_THR_W-1:0] thr;  // threshold code
        logic sync1;        // comparator sync, first stage
        logic sync2;        // comparator sync, second stage
        logic power_on_clear_circuit;          // power-on-clear reset output
        logic [7:0] rdata;  // read data register
    } rcd_state_t;

    localparam rcd_state_t RCD_STATE_RST = '{
        wdt_flag: RCD_CAUSE_RST[RCD_CAUSE_WDT_BIT],
        lv_flag: RCD_CAUSE_RST[RCD_CAUSE_LV_BIT],
        en: RCD_CTRL_RST[RCD_CTRL_EN_BIT],
        mode: RCD_CTRL_RST[RCD_CTRL_MODE_BIT],
        thr: RCD_THR_RST[RCD_THR_W-1:0],
        sync1: 1'b0,
        sync2: 1'b0,
        power_on_clear_circuit: 1'b1,          // reset held from power-up
        rdata: 8'h00
    };

    rcd_state_t state_q;    // registered state
    rcd_state_t state_d;    // next state
    logic rst_meta_q;       // reset release, first stage
    logic rst_n_q;          // reset release, second stage
    logic flag;             // low-voltage flag value
    logic lvi_rst;          // detector reset request
    logic rd_cause;         // read of the cause register
    logic wr_ctrl_byte;     // byte write to control register
    logic wr_ctrl_bit;      // bit write to control register
    logic [7:0] ctrl_rd;    // control register read view
    logic [7:0] cause_rd;   // cause register read view
    logic [7:0] thr_rd;     // threshold register read view

    // ============================================================
    // reset release through two flip-flops
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rst_meta_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q <= rst_meta_q;
        end
    end

    // ============================================================
    // detector outputs from the synchronised comparator
    always_comb begin
        flag = state_q.en & state_q.sync2;
        lvi_rst = flag & state_q.mode;
        rd_cause = i_req.rd && (i_req.addr == RCD_CAUSE_ADDR);
        wr_ctrl_byte = i_req.wr && (i_req.addr == RCD_DET_CTRL_ADDR);
        wr_ctrl_bit = i_req.bit_wr && (i_req.addr == RCD_DET_CTRL_ADDR);
        // read views, unused bits zero
        ctrl_rd = 8'h00;
        ctrl_rd[RCD_CTRL_EN_BIT] = state_q.en;
        ctrl_rd[RCD_CTRL_MODE_BIT] = state_q.mode;
        ctrl_rd[RCD_CTRL_FLAG_BIT] = flag;
        cause_rd = 8'h00;
        cause_rd[RCD_CAUSE_WDT_BIT] = state_q.wdt_flag;
        cause_rd[RCD_CAUSE_LV_BIT] = state_q.lv_flag;
        thr_rd = 8'h00;
        thr_rd[RCD_THR_W-1:0] = state_q.thr;
    end

    // ============================================================
    // next-state logic
    always_comb begin
        state_d = state_q;
        // comparator synchroniser
        state_d.sync1 = i_evt.cmp_below;
        state_d.sync2 = state_q.sync1;
        // power-on-clear follows the supply comparison
        state_d.power_on_clear_circuit = i_evt.poc_below;
        // read data path, last read held while no read strobe
        if (i_req.rd) begin
            if (i_req.addr == RCD_DET_CTRL_ADDR) begin
                state_d.rdata = ctrl_rd;
            end else if (i_req.addr == RCD_THR_SEL_ADDR) begin
                state_d.rdata = thr_rd;
            end else if (i_req.addr == RCD_CAUSE_ADDR) begin
                state_d.rdata = cause_rd;
            end else begin
                state_d.rdata = RCD_UNMAPPED_RD;      // unmapped read
            end
        end
        // control register: byte write, bit 0 ignored
        if (wr_ctrl_byte) begin
            state_d.en = i_req.wdata[RCD_CTRL_EN_BIT];
            state_d.mode = i_req.wdata[RCD_CTRL_MODE_BIT];
        end
        // control register: single-bit write
        if (wr_ctrl_bit) begin
            if (i_req.bit_idx == 3'(RCD_CTRL_EN_BIT)) begin
                state_d.en = i_req.bit_val;
            end
            if (i_req.bit_idx == 3'(RCD_CTRL_MODE_BIT)) begin
                state_d.mode = i_req.bit_val;
            end
        end
        // threshold register: byte writes only, code kept as written
        if (i_req.wr && i_req.addr == RCD_THR_SEL_ADDR) begin
            state_d.thr = i_req.wdata[RCD_THR_W-1:0];
        end
        // cause register: a read clears, a set wins over that
        if (rd_cause) begin
            state_d.wdt_flag = 1'b0;
            state_d.lv_flag = 1'b0;
        end
        if (lvi_rst) begin
            // detector reset: control and threshold held
            state_d.lv_flag = 1'b1;
            state_d.en = state_q.en;
            state_d.mode = state_q.mode;
            state_d.thr = state_q.thr;
        end else if (i_evt.wdt_req) begin
            // watchdog reset clears control, keeps other cause flag
            state_d.en = RCD_CTRL_RST[RCD_CTRL_EN_BIT];
            state_d.mode = RCD_CTRL_RST[RCD_CTRL_MODE_BIT];
            state_d.thr = RCD_THR_RST[RCD_THR_W-1:0];
        end
        if (i_evt.wdt_req) begin
            state_d.wdt_flag = 1'b1;
        end
        // power-on-clear wipes cause flags, control and threshold; synchroniser and read data kept
        if (state_q.power_on_clear_circuit) begin
            state_d.wdt_flag = RCD_STATE_RST.wdt_flag;
            state_d.lv_flag = RCD_STATE_RST.lv_flag;
            state_d.en = RCD_STATE_RST.en;
            state_d.mode = RCD_STATE_RST.mode;
            state_d.thr = RCD_STATE_RST.thr;
        end
    end

    // ============================================================
    // state register, cleared by the external pin
    always_ff @(posedge i_ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            state_q <= RCD_STATE_RST;
        end else begin
            state_q <= state_d;
        end
    end

    // ============================================================
    // outputs
    assign o_rdata = state_q.rdata;
    assign o_cmp_enable = state_q.en;
    assign o_level_code = state_q.thr;
    assign o_level_legal = (32'(state_q.thr) < NUM_LEVELS);
    assign o_low_voltage_flag = flag;
    assign o_low_voltage_irq = flag & ~state_q.mode;
    assign o_lvi_reset = lvi_rst;
    assign o_poc_reset = state_q.power_on_clear_circuit | ~rst_n_q;

    // ============================================================
    // assertions
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!rst_n_q);

    read_clears_cause_a: assert property (
        rd_cause && !i_evt.wdt_req && !lvi_rst |=>
            !state_q.wdt_flag && !state_q.lv_flag)
        else $error("cause register not cleared by read");

    wdt_sets_flag_a: assert property (
        i_evt.wdt_req && !state_q.power_on_clear_circuit |=> state_q.wdt_flag)
        else $error("watchdog cause flag not set");

    lvi_sets_flag_a: assert property (
        lvi_rst && !state_q.power_on_clear_circuit |=> state_q.lv_flag)
        else $error("low-voltage cause flag not set");

    wdt_keeps_lv_a: assert property (
        i_evt.wdt_req && !rd_cause && !lvi_rst && !state_q.power_on_clear_circuit |=>
            $stable(state_q.lv_flag))
        else $error("watchdog reset disturbed low-voltage flag");

    cause_read_zero_a: assert property (
        rd_cause |=> (o_rdata & 8'hEE) == 8'h00)
        else $error("unused cause bits read nonzero");

    poc_follows_supply_a: assert property (
        i_evt.poc_below |=> o_poc_reset ##1 !state_q.en)
        else $error("power-on-clear did not reset");

    flag_needs_enable_a: assert property (
        !state_q.en |-> !o_low_voltage_flag && !o_low_voltage_irq)
        else $error("flag set while detection disabled");

    flag_write_ignored_a: assert property (
        wr_ctrl_bit && i_req.bit_idx == 3'h0 && !lvi_rst &&
            !i_evt.wdt_req && !state_q.power_on_clear_circuit |=>
            $stable(state_q.en) && $stable(state_q.mode))
        else $error("write to flag bit changed control");

    irq_mode_a: assert property (
        o_low_voltage_irq |-> !state_q.mode && o_low_voltage_flag &&
            !o_lvi_reset)
        else $error("interrupt raised outside interrupt mode");

    lvi_holds_ctrl_a: assert property (
        lvi_rst && !state_q.power_on_clear_circuit |=> $stable(state_q.thr) &&
            state_q.en)
        else $error("detector reset cleared its own registers");

    sync_delay_a: assert property (
        (i_evt.cmp_below && state_q.en && !state_q.power_on_clear_circuit)[*3] |->
            o_low_voltage_flag)
        else $error("comparator not seen after two stages");

    wdt_clears_ctrl_a: assert property (
        i_evt.wdt_req && !lvi_rst |=> !state_q.en && !state_q.mode &&
            state_q.thr == RCD_THR_RST[RCD_THR_W-1:0])
        else $error("watchdog reset left detector registers set");

    thr_bit_ignored_a: assert property (
        i_req.bit_wr && !i_req.wr && i_req.addr == RCD_THR_SEL_ADDR &&
            !i_evt.wdt_req && !state_q.power_on_clear_circuit |=> $stable(state_q.thr))
        else $error("bit write changed threshold code");

    ctrl_bit_set_a: assert property (
        wr_ctrl_bit && i_req.bit_idx == 3'(RCD_CTRL_EN_BIT) &&
            i_req.bit_val && !lvi_rst && !i_evt.wdt_req &&
            !state_q.power_on_clear_circuit |=> o_cmp_enable)
        else $error("enable bit write did not start comparator");

    poc_clears_cause_a: assert property (
        state_q.power_on_clear_circuit |=> !state_q.wdt_flag && !state_q.lv_flag)
        else $error("power-on-clear left a cause flag set");

    lvi_level_a: assert property (
        state_q.en && state_q.mode |-> o_lvi_reset == state_q.sync2)
        else $error("detector reset not following supply level");

    irq_follows_flag_a: assert property (
        state_q.en && !state_q.mode |->
            o_low_voltage_irq == o_low_voltage_flag)
        else $error("interrupt request not following flag");

    sync_low_a: assert property (
        (!i_evt.cmp_below)[*3] |-> !o_low_voltage_flag)
        else $error("flag set without comparator low");

endmodule

// [rcd_reset_cause_tb.sv]
`timescale 1ns/1ps

// ============================================================
// self-checking bench of the reset cause block
module rcd_reset_cause_tb
    import rcd_pkg::*;
;
    logic i_ref_clk = 1'b0;      // system clock
    logic i_resetn = 1'b0;       // external reset pin
    rcd_req_t req = '0;          // register requests
    rcd_evt_t evt = '0;          // chip events
    logic [7:0] o_rdata;
    logic o_cmp_enable;
    logic [RCD_THR_W-1:0] o_level_code;
    logic o_level_legal;
    logic o_low_voltage_flag;
    logic o_low_voltage_irq;
    logic o_lvi_reset;
    logic o_poc_reset;
    int failures = 0;            // mismatches seen
    int total_checks = 0;        // comparisons made
    int cycles = 0;              // hang guard
    int m_en = 0;                // model: enable bit
    int m_mode = 0;              // model: action select
    int m_thr = 0;               // model: threshold code
    int m_cause = 0;             // model: cause flags
    int m_below = 0;             // model: synced comparator

    // ============================================================
    // clock and design
    initial begin
        forever #2 i_ref_clk = ~i_ref_clk;
    end

    rcd_reset_cause #(.NUM_LEVELS(RCD_NUM_LEVELS)) dut (
        .i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_req(req),
        .i_evt(evt), .o_rdata(o_rdata), .o_cmp_enable(o_cmp_enable),
        .o_level_code(o_level_code), .o_level_legal(o_level_legal),
        .o_low_voltage_flag(o_low_voltage_flag),
        .o_low_voltage_irq(o_low_voltage_irq),
        .o_lvi_reset(o_lvi_reset), .o_poc_reset(o_poc_reset)
    );

    // ============================================================
    // reporting
    task automatic wrap_up;
        if (failures == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // hang guard, far above the few hundred cycles needed
    always @(posedge i_ref_clk) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            wrap_up();
        end
    end

    // ============================================================
    // model helpers
    function automatic logic [7:0] exp_rd(input logic [15:0] a);
        case (a)
            RCD_DET_CTRL_ADDR: return 8'(m_en * 128 + m_mode * 2
                                        + (m_en & m_below));
            RCD_THR_SEL_ADDR: return 8'(m_thr);
            RCD_CAUSE_ADDR: return 8'(m_cause);
            default: return RCD_UNMAPPED_RD;
        endcase
    endfunction

    task automatic clr_model;
        m_en = 0;
        m_mode = 0;
        m_thr = 0;
        m_cause = 0;
    endtask

    // all detector outputs against the model
    task automatic check_all;
        int f;
        f = m_en & m_below;
        chk(8'(o_cmp_enable), 8'(m_en));
        chk(8'(o_level_code), 8'(m_thr));
        chk(8'(o_level_legal), 8'(m_thr < RCD_NUM_LEVELS));
        chk(8'(o_low_voltage_flag), 8'(f));
        chk(8'(o_low_voltage_irq), 8'(f && !m_mode));
        chk(8'(o_lvi_reset), 8'(f && m_mode));
    endtask

    // ============================================================
    // bus cycles, entered at a falling edge
    // whole-byte reads only, never a bit read
    task automatic rd(input logic [15:0] a);
        logic [7:0] e;
        e = exp_rd(a);
        req.rd = 1'b1;
        req.addr = a;
        @(negedge i_ref_clk);
        req.rd = 1'b0;
        chk(o_rdata, e);
        if (a == RCD_CAUSE_ADDR) m_cause = 0;
        @(negedge i_ref_clk);
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        req.wr = 1'b1;
        req.addr = a;
        req.wdata = d;
        @(negedge i_ref_clk);
        req.wr = 1'b0;
        if (a == RCD_DET_CTRL_ADDR) begin
            m_en = d[7];
            m_mode = d[1];
        end else if (a == RCD_THR_SEL_ADDR) begin
            m_thr = d[3:0];
        end
        @(negedge i_ref_clk);
    endtask

    task automatic bwr(input logic [15:0] a, input logic [2:0] i,
                       input logic v);
        req.bit_wr = 1'b1;
        req.addr = a;
        req.bit_idx = i;
        req.bit_val = v;
        @(negedge i_ref_clk);
        req.bit_wr = 1'b0;
        if (a == RCD_DET_CTRL_ADDR && i == 3'h7) m_en = v;
        if (a == RCD_DET_CTRL_ADDR && i == 3'h1) m_mode = v;
        @(negedge i_ref_clk);
    endtask

    // comparator step: old value one edge on, new after two
    task automatic cmpset(input logic v);
        evt.cmp_below = v;
        @(negedge i_ref_clk);
        check_all;
        @(negedge i_ref_clk);
        m_below = v;
        check_all;
        if (m_en && m_mode && m_below) m_cause |= 1;
    endtask

    task automatic pulse_wdt;
        evt.wdt_req = 1'b1;
        @(negedge i_ref_clk);
        evt.wdt_req = 1'b0;
        m_cause |= 16;
        m_en = 0;
        m_mode = 0;
        m_thr = 0;
        @(negedge i_ref_clk);
    endtask

    // ============================================================
    // main sequence
    initial begin
        void'($urandom(32'h802CA8BD));
        repeat (4) @(negedge i_ref_clk);
        i_resetn = 1'b1;
        repeat (4) @(negedge i_ref_clk);
        check_all;
        chk(8'(o_poc_reset), 8'h00);
        rd(RCD_CAUSE_ADDR);
        rd(RCD_DET_CTRL_ADDR);
        rd(RCD_THR_SEL_ADDR);
        rd(16'hFF52);
        // every code, detector off, upper bits zero
        for (int c = 0; c < 16; c++) begin
            wr(RCD_THR_SEL_ADDR, 8'(c));
            check_all;
            rd(RCD_THR_SEL_ADDR);
        end
        bwr(RCD_THR_SEL_ADDR, 3'h2, 1'b1);
        rd(RCD_THR_SEL_ADDR);
        // random control bytes, spare bits 2-6 kept zero
        for (int i = 0; i < 8; i++) begin
            wr(RCD_DET_CTRL_ADDR, 8'($urandom) & 8'h83);
            check_all;
            rd(RCD_DET_CTRL_ADDR);
        end
        wr(RCD_DET_CTRL_ADDR, 8'h00);
        // bit writes: ones only to bits 0, 1 and 7
        for (int b = 0; b < 16; b++) begin
            bwr(RCD_DET_CTRL_ADDR, 3'(b),
                b < 8 && !(b inside {[2:6]}));
            rd(RCD_DET_CTRL_ADDR);
        end
        wr(RCD_CAUSE_ADDR, 8'hFF);
        bwr(RCD_CAUSE_ADDR, 3'h4, 1'b1);
        rd(RCD_CAUSE_ADDR);
        // interrupt mode, then disable by bit clear
        wr(RCD_THR_SEL_ADDR, 8'h03);
        // bench comparator is ideal, so flag trusted at once
        wr(RCD_DET_CTRL_ADDR, 8'h80);
        cmpset(1'b1);
        rd(RCD_DET_CTRL_ADDR);
        bwr(RCD_DET_CTRL_ADDR, 3'h7, 1'b0);
        check_all;
        cmpset(1'b0);
        // reset mode chosen above threshold, then supply drops
        wr(RCD_DET_CTRL_ADDR, 8'h82);
        check_all;
        rd(RCD_CAUSE_ADDR);
        cmpset(1'b1);
        @(negedge i_ref_clk);
        rd(RCD_DET_CTRL_ADDR);
        rd(RCD_THR_SEL_ADDR);
        cmpset(1'b0);
        pulse_wdt;
        check_all;
        rd(RCD_CAUSE_ADDR);
        rd(RCD_CAUSE_ADDR);
        // power-on clear in mid-run
        pulse_wdt;
        wr(RCD_THR_SEL_ADDR, 8'h05);
        wr(RCD_DET_CTRL_ADDR, 8'h80);
        evt.poc_below = 1'b1;
        repeat (2) @(negedge i_ref_clk);
        chk(8'(o_poc_reset), 8'h01);
        evt.poc_below = 1'b0;
        repeat (3) @(negedge i_ref_clk);
        chk(8'(o_poc_reset), 8'h00);
        clr_model;
        check_all;
        rd(RCD_CAUSE_ADDR);
        // pin reset in mid-run
        pulse_wdt;
        wr(RCD_THR_SEL_ADDR, 8'h07);
        wr(RCD_DET_CTRL_ADDR, 8'h82);
        i_resetn = 1'b0;
        repeat (2) @(negedge i_ref_clk);
        clr_model;
        check_all;
        chk(o_rdata, 8'h00);
        chk(8'(o_poc_reset), 8'h01);
        i_resetn = 1'b1;
        repeat (4) @(negedge i_ref_clk);
        rd(RCD_CAUSE_ADDR);
        rd(RCD_DET_CTRL_ADDR);
        wrap_up();
    end
endmodule
